/* File: design/adc_defs.svh */
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// System clock and internal converter clock
`define CLK_FREQ_MHZ 100
`define CONV_CLK_PERIOD_NS 400
`define CONV_HALF_DIV ((`CONV_CLK_PERIOD_NS * `CLK_FREQ_MHZ) / 2000)

// Result and serial word layout
`define RESULT_W 12
`define BYTE_W 8
`define SER_WORD_BITS 16
`define RESULT_RESET 12'h000
`define SAR_FIRST_TRIAL 12'h800
`define SAR_TOP_BIT 4'hb

// Converter clock ticks of one conversion frame
`define TICK_FRAME_START 5'd1
`define TICK_LAST_DECISION 5'd12
`define TICK_LAST_ZERO 5'd4
`define TICK_LAST_BIT 5'd16
`define TICK_END 5'd17

// Output enable masks of the parallel bus
`define OE_WORD 12'hfff
`define OE_BYTE 12'h0ff

// Serial pin positions in the open-drain pin vector
`define SER_FRAME_STROBE 0
`define SER_CLOCK 1
`define SER_OUT_LINE 2

`define FIFO_DEPTH 4

`endif

/* File: design/adc_pkg.sv */
package adc_pkg;
    // Level of the three-function format pin
    typedef enum logic [1:0] {FMT_PARALLEL, FMT_SERIAL_BURST, FMT_SERIAL_CONT} format_t;
    typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;
endpackage : adc_pkg

/* File: design/stream_if.sv */
interface stream_if #(parameter int W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

/* File: design/conv_clock_gen.sv */
`include "adc_defs.svh"

// Converter clock: internal divider or sampled external clock
module conv_clock_gen #(
    parameter int HALF_DIV = `CONV_HALF_DIV
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic clk_en, // freezes state when low
    input wire logic ext_select, // 1: use external clock
    input wire logic ext_clock, // external converter clock
    output logic level, // converter clock level
    output logic rise // one-cycle pulse on rising edge
);
    localparam int CW = $clog2(HALF_DIV + 1);
    logic [CW-1:0] cnt;

    // Divider counter, idle while the external clock is used
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= '0;
        else if (clk_en)
        begin
            if (ext_select || cnt == CW'(HALF_DIV - 1))
                cnt <= '0;
            else
                cnt <= cnt + 1'b1;
        end
    end

    // Level and rising-edge pulse from whichever source is active
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level <= 1'b0;
            rise <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ext_select)
            begin
                level <= ext_clock;
                rise <= ext_clock & ~level;
            end
            else if (cnt == CW'(HALF_DIV - 1))
            begin
                level <= ~level;
                rise <= ~level;
            end
            else
                rise <= 1'b0;
        end
    end
endmodule : conv_clock_gen

/* File: design/result_fifo.sv */
// Small result FIFO; storage is flops, read data straight from them
module result_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic clk_en, // freezes state when low
    stream_if.snk wr, // fill side
    output logic rd_valid, // head word present
    input wire logic rd_ready, // drain side takes head
    output logic [W-1:0] rd_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign wr.ready = count != (AW + 1)'(DEPTH);
    assign rd_valid = count != '0;
    assign rd_data = mem[rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd_valid && rd_ready;

    // Storage has no reset; only pointers and fill count need defined values
    always_ff @(posedge clk)
    begin
        if (clk_en && push)
            mem[wp] <= wr.data;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end
        else if (clk_en)
        begin
            if (push)
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            if (pop)
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule : result_fifo

/* File: design/sampling_adc_host_interface.sv */
`include "adc_defs.svh"

// How it works
// - Start falling edge begins conversion, enters hold
// - Track/hold returns to tracking at completion
// - Format pin high gives parallel only
// - Parallel format drives all twelve bits together
// - Byte read: low byte, or zero-padded high nibble
// - Serial formats reuse three upper pins
// - Serial word: four zeros, then result MSB first
// - Bit changes on clock rise, valid on fall
// - Strobe low within three clocks of start
// - Serial lines are open-drain, pull low only
// - Serial clock follows active converter clock source
// - Continuous serial clock at -5 V, burst at 0 V
// - End flag idles high, goes low when done
// - End flag cleared by first read falling edge
// - Parallel drivers enabled only while reading
// - Held read shows the new result, flag stays low
// - No serial output in parallel format
// - Start accepted independent of clock and reads
// - Result is two's complement
module sampling_adc_host_interface #(
    parameter int HALF_DIV = `CONV_HALF_DIV,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic conversion_start_n, // falling edge starts conversion
    input wire logic cs_n, // chip select, active low
    input wire logic rd_n, // read strobe, active low
    input wire logic high_byte_select, // byte format: 1 selects high byte
    input wire adc_pkg::format_t format, // level of the format pin
    input wire logic ext_clock_select, // 1: external converter clock
    input wire logic ext_conv_clock, // external converter clock
    input wire logic comparator_above, // input at or above the trial level
    output logic track_hold_hold, // 1: hold, 0: track
    output logic [`RESULT_W-1:0] dac_trial, // trial code to the DAC
    output logic end_of_conversion_n, // end of conversion flag
    output logic [`RESULT_W-1:0] data_bus_out, // parallel data
    output logic [`RESULT_W-1:0] data_bus_oe, // parallel drive enables
    input wire logic [2:0] serial_pins_in, // serial pin levels, unused
    output logic [2:0] serial_pins_out, // always low, open drain
    output logic [2:0] serial_pins_oe, // 1: pulling the pin low
    output logic result_valid, // result stream word present
    input wire logic result_ready, // result stream consumer ready
    output logic [`RESULT_W-1:0] result_data, // result stream word
    output logic busy // conversion in progress
);
    import adc_pkg::*;

    // Sequencer
    conv_state_t state;
    logic [4:0] tick_cnt;
    logic [4:0] tick_next;

    // Successive approximation and result
    logic [3:0] sar_bit;
    logic [`RESULT_W-1:0] kept;
    logic [`RESULT_W-1:0] next_trial;
    logic [`RESULT_W-1:0] result_word;
    logic [`RESULT_W-1:0] result;
    logic [`RESULT_W-1:0] next_bus;

    // Start and read strobe edges
    logic start_prev;
    logic start_fall;
    logic start_accept;
    logic read_active;
    logic read_prev;
    logic read_fall;

    // Converter clock ticks
    logic conv_level;
    logic conv_rise;
    logic conv_tick;
    logic conv_done;

    // Serial frame
    logic [3:0] ser_sel;
    logic frame;
    logic ser_bit;
    logic serial_mode;

    stream_if #(.W(`RESULT_W)) push ();

    // Converter clock from internal divider or external source
    conv_clock_gen #(
        .HALF_DIV(HALF_DIV)
    ) u_clock (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .ext_select(ext_clock_select),
        .ext_clock(ext_conv_clock),
        .level(conv_level),
        .rise(conv_rise)
    );

    // Completed results queue for a streaming consumer
    result_fifo #(
        .W(`RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr(push),
        .rd_valid(result_valid),
        .rd_ready(result_ready),
        .rd_data(result_data)
    );

    // Start edge; refused while busy or with the queue full
    assign start_fall = start_prev & ~conversion_start_n;
    assign start_accept = (state == ST_IDLE) && start_fall && push.ready;

    // Converter ticks only count inside a conversion
    assign conv_tick = (state == ST_CONVERT) && conv_rise;
    assign tick_next = tick_cnt + 5'd1;
    assign conv_done = conv_tick && (tick_next == `TICK_END);

    // Read strobe is both selects low together
    assign read_active = ~cs_n & ~rd_n;
    assign read_fall = read_active & ~read_prev;

    // Format pin and status
    assign serial_mode = (format != FMT_PARALLEL);
    assign busy = (state == ST_CONVERT);

    // Offset-binary search word turned into two's complement
    assign result_word = {~dac_trial[`RESULT_W-1], dac_trial[`RESULT_W-2:0]};

    // Completed word enters the FIFO; space was checked at start
    assign push.valid = conv_done;
    assign push.data = result_word;

    // Start history; resets high so a pin held low counts as an edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            start_prev <= 1'b1;
        else if (clk_en)
            start_prev <= conversion_start_n;
    end

    // Read strobe history; idle level so reset makes no false edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            read_prev <= 1'b0;
        else if (clk_en)
            read_prev <= read_active;
    end

    // Conversion state; starts during a conversion are ignored
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_IDLE;
        else if (clk_en)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start_accept)
                        state <= ST_CONVERT;
                end
                ST_CONVERT:
                begin
                    if (conv_done)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Tick count within the frame, cleared at each accepted start
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tick_cnt <= 5'd0;
        else if (clk_en)
        begin
            if (start_accept)
                tick_cnt <= 5'd0;
            else if (conv_tick)
                tick_cnt <= tick_next;
        end
    end

    // Track/hold: hold from the accepted start to the last tick
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            track_hold_hold <= 1'b0;
        else if (clk_en)
        begin
            if (start_accept)
                track_hold_hold <= 1'b1;
            else if (conv_done)
                track_hold_hold <= 1'b0;
        end
    end

    // Keep or drop the bit on trial, then try the next lower one
    always_comb
    begin
        kept = dac_trial;
        if (!comparator_above)
            kept[sar_bit] = 1'b0;
        next_trial = kept;
        if (sar_bit != 4'h0)
            next_trial[sar_bit - 4'h1] = 1'b1;
    end

    // Successive approximation, one decision per converter tick for ticks 1 to 12
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dac_trial <= `RESULT_RESET;
        else if (clk_en)
        begin
            if (start_accept)
                dac_trial <= `SAR_FIRST_TRIAL;
            else if (conv_tick && tick_next <= `TICK_LAST_DECISION)
                dac_trial <= next_trial;
        end
    end

    // Bit under trial walks down from the top; stops at bit 0
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sar_bit <= `SAR_TOP_BIT;
        else if (clk_en)
        begin
            if (start_accept)
                sar_bit <= `SAR_TOP_BIT;
            else if (conv_tick && tick_next <= `TICK_LAST_DECISION && sar_bit != 4'h0)
                sar_bit <= sar_bit - 4'h1;
        end
    end

    // Result bit sent at a given tick; bit 11 goes out at tick 5
    assign ser_sel = 4'(`TICK_LAST_BIT - tick_next);

    // Serial frame strobe, low on the pin from tick 1 to tick 16
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            frame <= 1'b0;
        else if (clk_en && conv_tick)
        begin
            if (tick_next == `TICK_FRAME_START)
                frame <= 1'b1;
            else if (tick_next == `TICK_END)
                frame <= 1'b0;
        end
    end

    // Data bit launched on converter clock rise, steady until its fall
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ser_bit <= 1'b1;
        else if (clk_en && conv_tick)
        begin
            if (tick_next <= `TICK_LAST_ZERO)
                ser_bit <= 1'b0;
            else if (tick_next <= `TICK_LAST_BIT)
                ser_bit <= result_word[ser_sel];
            else
                ser_bit <= 1'b1;
        end
    end

    // Output word register; updated only when a conversion ends
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            result <= `RESULT_RESET;
        else if (clk_en && conv_done)
            result <= result_word;
    end

    // End flag: a completion in the same cycle as a read wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            end_of_conversion_n <= 1'b1;
        else if (clk_en)
        begin
            if (conv_done)
                end_of_conversion_n <= 1'b0;
            else if (read_fall)
                end_of_conversion_n <= 1'b1;
        end
    end

    // Format picks word or byte layout of the latched result
    always_comb
    begin
        if (!serial_mode)
            next_bus = result;
        else if (high_byte_select)
            next_bus = {8'h00, result[`RESULT_W-1:`BYTE_W]};
        else
            next_bus = {4'h0, result[`BYTE_W-1:0]};
    end

    // Bus data register; a byte select change shows one clock later
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            data_bus_out <= `RESULT_RESET;
        else if (clk_en)
            data_bus_out <= next_bus;
    end

    // Drivers only while both selects are low; upper pins serve serial
    always_comb
    begin
        if (!read_active)
            data_bus_oe = '0;
        else if (!serial_mode)
            data_bus_oe = `OE_WORD;
        else
            data_bus_oe = `OE_BYTE;
    end

    // Open-drain serial lines only ever pull low
    assign serial_pins_out = 3'h0;
    assign serial_pins_oe[`SER_FRAME_STROBE] = serial_mode & frame;
    assign serial_pins_oe[`SER_OUT_LINE] = serial_mode & frame & ~ser_bit;
    // Clock is the converter clock itself; burst mode stops it after the frame
    assign serial_pins_oe[`SER_CLOCK] = serial_mode & ~conv_level
        & ((format == FMT_SERIAL_CONT) | frame);
endmodule : sampling_adc_host_interface

/* File: test/host_link_model.sv */
// Far side: comparator, pull-ups and a serial receiver
module host_link_model (
    input wire logic clk, // system clock
    input wire logic nrst, // reset, active low
    input wire logic [11:0] dac_trial, // trial code
    input wire logic [2:0] serial_pins_oe, // pulling low
    input wire logic [11:0] vin, // input as offset binary code
    output logic comparator_above, // input at or above trial
    output logic [2:0] serial_pins_in, // resolved pin levels
    output logic [15:0] word, // last bits shifted in
    output logic [4:0] nbits, // bits taken in this frame
    output logic [7:0] nfall // serial clock falls seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_stb;
    logic prev_sck;
    // Ideal comparator, no noise or offset
    assign comparator_above = (vin >= dac_trial);
    // Released lines read high through the pull-ups
    assign serial_pins_in = ~serial_pins_oe;
    // Falls are seen one clock late; data is still steady then
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_stb <= 1'b1;
            prev_sck <= 1'b1;
            word <= 16'h0000;
            nbits <= 5'h00;
            nfall <= 8'h00;
        end
        else
        begin
            prev_stb <= serial_pins_in[0];
            prev_sck <= serial_pins_in[1];
            if (prev_sck && !serial_pins_in[1])
                nfall <= nfall + 8'h01;
            if (prev_stb && !serial_pins_in[0])
                nbits <= 5'h00;
            else if (!serial_pins_in[0] && prev_sck && !serial_pins_in[1])
            begin
                word <= {word[14:0], serial_pins_in[2]};
                nbits <= nbits + 5'h01;
            end
        end
    end
endmodule : host_link_model

/* File: test/adc_props.sv */
module adc_props #(
    parameter int HALF_DIV = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic conversion_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire adc_pkg::format_t format,
    input wire logic track_hold_hold,
    input wire logic [11:0] dac_trial,
    input wire logic end_of_conversion_n,
    input wire logic [11:0] data_bus_oe,
    input wire logic [2:0] serial_pins_out,
    input wire logic [2:0] serial_pins_oe,
    input wire logic result_valid,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import adc_pkg::*;
    // Three converter clocks plus the edge detect delay
    localparam int STB_MAX = 6 * HALF_DIV + 3;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    start_hold_a: assert property (clk_en && !busy && !result_valid
        && $fell(conversion_start_n) |=> track_hold_hold && busy)
        else $error("start edge did not enter hold");
    hold_track_a: assert property (track_hold_hold == busy)
        else $error("hold and conversion disagree");
    dac_first_a: assert property ($rose(busy) |-> dac_trial == 12'h800)
        else $error("first trial is not the top bit");
    eoc_set_a: assert property ($fell(busy) |=> !end_of_conversion_n)
        else $error("end flag not low after conversion");
    eoc_clear_a: assert property ($fell(cs_n | rd_n) && !busy
        && !end_of_conversion_n |-> ##[1:2] end_of_conversion_n)
        else $error("end flag not cleared by read");
    oe_off_a: assert property (cs_n || rd_n |-> data_bus_oe == 12'h000)
        else $error("bus driven outside read");
    oe_word_a: assert property (!cs_n && !rd_n && format == FMT_PARALLEL
        |-> data_bus_oe == 12'hfff)
        else $error("word read not driving all lines");
    no_serial_a: assert property (format == FMT_PARALLEL |-> serial_pins_oe == 3'b000)
        else $error("serial activity in word format");
    drain_only_a: assert property (serial_pins_out == 3'b000)
        else $error("serial line driven high");
    strobe_soon_a: assert property ($rose(busy) && format != FMT_PARALLEL
        |-> ##[0:STB_MAX] serial_pins_oe[0])
        else $error("frame strobe late");
    burst_quiet_a: assert property (format == FMT_SERIAL_BURST
        && !serial_pins_oe[0] |-> !serial_pins_oe[1])
        else $error("burst clock outside frame");
endmodule : adc_props
bind sampling_adc_host_interface adc_props #(.HALF_DIV(HALF_DIV)) u_adc_props (
    .clk, .nrst, .clk_en, .conversion_start_n, .cs_n, .rd_n, .format, .track_hold_hold,
    .dac_trial, .end_of_conversion_n, .data_bus_oe, .serial_pins_out, .serial_pins_oe,
    .result_valid, .busy
);

/* File: test/sampling_adc_host_interface_tb.sv */
module sampling_adc_host_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_pkg::*;
    logic clk, nrst, conversion_start_n, cs_n, rd_n, high_byte_select, ok;
    logic ext_clock_select, ext_conv_clock, comparator_above, track_hold_hold;
    logic end_of_conversion_n, result_valid, result_ready, busy;
    format_t format;
    logic [11:0] vin, dac_trial, data_bus_out, data_bus_oe, result_data;
    logic [2:0] serial_pins_in, serial_pins_out, serial_pins_oe;
    logic [15:0] word;
    logic [4:0] nbits;
    logic [7:0] nfall, falls;
    int fail_count = 0;
    int n_compared = 0;
    sampling_adc_host_interface #(.HALF_DIV(2), .FIFO_DEPTH(4)) u_sampling_adc_host_interface (
        .clk, .nrst, .clk_en(1'b1), .conversion_start_n, .cs_n, .rd_n, .high_byte_select,
        .format, .ext_clock_select, .ext_conv_clock, .comparator_above, .track_hold_hold,
        .dac_trial, .end_of_conversion_n, .data_bus_out, .data_bus_oe, .serial_pins_in,
        .serial_pins_out, .serial_pins_oe, .result_valid, .result_ready, .result_data, .busy
    );
    host_link_model u_host_link_model (
        .clk, .nrst, .dac_trial, .serial_pins_oe, .vin, .comparator_above, .serial_pins_in,
        .word, .nbits, .nfall
    );
    // System clock, 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // External converter clock, six system clocks a period, driven off the sampling edge
    initial
    begin
        ext_conv_clock = 1'b0;
        forever
        begin
            repeat (3) @(posedge clk);
            ext_conv_clock <= ~ext_conv_clock;
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // One start pulse; reports whether the converter took it
    task automatic convert(input logic [11:0] v, output logic taken);
        int i;
        @(posedge clk);
        vin <= v;
        conversion_start_n <= 1'b0;
        taken = 1'b0;
        for (i = 0; i < 6 && !taken; i++)
        begin
            @(negedge clk);
            taken = (busy === 1'b1);
        end
        @(posedge clk);
        conversion_start_n <= 1'b1;
        for (i = 0; i < 200 && busy !== 1'b0; i++)
            @(negedge clk);
        repeat (3) @(negedge clk);
        check("hold", 16'(track_hold_hold), 16'h0000);
    endtask : convert
    // Host read cycle held for three clocks
    task automatic read_bus(input logic hb, input logic [11:0] exp_d, input logic [11:0] exp_oe);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        high_byte_select <= hb;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("bus", 16'(data_bus_out), 16'(exp_d));
        check("bus enable", 16'(data_bus_oe), 16'(exp_oe));
        check("end flag", 16'(end_of_conversion_n), 16'h0001);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : read_bus
    // Watchdog: a hang counts as a mismatch
    initial
    begin
        #100000;
        fail_count++;
        final_report();
    end
    // Test sequence
    initial
    begin
        nrst = 1'b0;
        conversion_start_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        high_byte_select = 1'b0;
        format = FMT_PARALLEL;
        ext_clock_select = 1'b0;
        result_ready = 1'b1;
        vin = 12'h000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        // Word format, most negative code
        convert(12'h000, ok);
        check("end flag low", 16'(end_of_conversion_n), 16'h0000);
        read_bus(1'b0, 12'h800, 12'hfff);
        // Read held low across a conversion
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        convert(12'hfff, ok);
        repeat (5) @(negedge clk);
        check("held bus", 16'(data_bus_out), 16'h07ff);
        check("held flag", 16'(end_of_conversion_n), 16'h0000);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        format <= FMT_SERIAL_BURST;
        // Byte and burst serial format, high byte first
        convert(12'ha5c, ok);
        check("serial word", word, 16'h025c);
        check("serial bits", 16'(nbits), 16'h0010);
        read_bus(1'b1, 12'h002, 12'h0ff);
        read_bus(1'b0, 12'h05c, 12'h0ff);
        falls = nfall;
        repeat (10) @(negedge clk);
        check("burst stopped", 16'(nfall), 16'(falls));
        // Continuous clock from the external source
        @(posedge clk);
        format <= FMT_SERIAL_CONT;
        ext_clock_select <= 1'b1;
        convert(12'h3c7, ok);
        check("ext serial word", word, 16'h0bc7);
        check("natural binary", 16'(word[11:0] ^ 12'h800), 16'(vin));
        falls = nfall;
        repeat (20) @(negedge clk);
        check("clock runs", 16'(nfall != falls), 16'h0001);
        // Stalled consumer: four results kept, fifth start refused
        @(posedge clk);
        format <= FMT_PARALLEL;
        ext_clock_select <= 1'b0;
        result_ready <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            convert(12'(12'h100 * k + 12'h011), ok);
            check("start taken", 16'(ok), 16'(k < 4));
        end
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            check("fifo word", 16'(result_data), 16'((12'h100 * k + 12'h011) ^ 12'h800));
            @(posedge clk);
            result_ready <= 1'b1;
            @(posedge clk);
            result_ready <= 1'b0;
        end
        @(negedge clk);
        check("fifo empty", 16'(result_valid), 16'h0000);
        final_report();
    end
endmodule : sampling_adc_host_interface_tb
